// File: core/imc_regs.sv
// Interrupt flags, command slots and identity registers of an I2C master.
// Assumes an AXI4-Lite master on aclk and the bus engine on link_clk, which
// pulses one-cycle events and reads the slot words only after a launch.
module imc_regs import imc_pkg::*; #(
   parameter logic [31:0] TX_BASE = 32'h0000_0000,
   parameter logic [31:0] RX_BASE = 32'h0000_0080,
   // Arbitrary revision value
   parameter logic [31:0] VERSION = 32'h0001_0000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   input wire logic link_clk,
   input wire logic link_resetn,
   input wire logic [N_IRQ-1:0] event_pulse,
   input wire logic [N_SLOT-1:0] slot_done_pulse,
   output logic link_launch,
   output logic [N_SLOT*32-1:0] slot_words,
   output logic [N_SLOT*CMD_OP_W-1:0] slot_ops,
   output logic [STALL_W-1:0] clock_fsm_stall_limit,
   output logic [STALL_W-1:0] main_fsm_stall_limit
);
   localparam int N_EV = N_IRQ + N_SLOT;

   initial begin
      if (N_SLOT != 8 || N_IRQ != 16 || DATA_W != 32) begin
         $error("imc_regs supports only 8 slots, 16 sources, 32-bit data");
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int b = 0; b < 4; b++) begin
         m[b*8 +: 8] = {8{strb[b]}};
      end
      return m;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] m;
      m = lane_mask(strb);
      return (old & ~m) | (data & m);
   endfunction

   // Index of the slot an address falls in, or N_SLOT when it misses
   function automatic logic [3:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [3:0] s;
      s = 4'(N_SLOT);
      for (int i = 0; i < N_SLOT; i++) begin
         if (a[7:2] == 6'(OFF_SLOT0[7:2] + 6'(i))) begin
            s = 4'(i);
         end
      end
      return s;
   endfunction

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      logic [5:0] w;
      w = a[7:2];
      return w == OFF_CONTROL[7:2] || w == OFF_INT_RAW[7:2] ||
         w == OFF_INT_CLR[7:2] || w == OFF_INT_ENA[7:2] ||
         w == OFF_INT_STATUS[7:2] || w == OFF_STALL[7:2] ||
         w == OFF_TX_BASE[7:2] || w == OFF_RX_BASE[7:2] ||
         w == OFF_VERSION[7:2] || slot_of(a) != 4'(N_SLOT);
   endfunction

   // Illegal opcodes are handed to the engine as END so it stops safely
   function automatic imc_op_t op_decode(input logic [CMD_OP_W-1:0] c);
      imc_op_t o;
      unique case (c)
         3'h0: o = OP_RESTART;
         3'h1: o = OP_WRITE;
         3'h2: o = OP_READ;
         3'h3: o = OP_STOP;
         default: o = OP_END;
      endcase
      return o;
   endfunction

   // ----------------------------------------------------------------
   // Link-side event capture
   // ----------------------------------------------------------------
   // A pulse flips a toggle bit, so a one-cycle pulse is not lost; two on one bit within an aclk cycle cancel
   logic [N_EV-1:0] ev_toggle;

   always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
         ev_toggle <= '0;
      end else begin
         ev_toggle <= ev_toggle ^ {slot_done_pulse, event_pulse};
      end
   end

   logic [N_EV-1:0] ev_sync1;
   logic [N_EV-1:0] ev_sync2;
   logic [N_EV-1:0] ev_seen;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ev_sync1 <= '0;
         ev_sync2 <= '0;
         ev_seen <= '0;
      end else begin
         ev_sync1 <= ev_toggle;
         ev_sync2 <= ev_sync1;
         ev_seen <= ev_sync2;
      end
   end

   logic [N_EV-1:0] ev_hit;
   assign ev_hit = ev_sync2 ^ ev_seen;

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   logic aw_got;
   logic w_got;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_go;

   assign wr_go = aw_got && w_got && !bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
      end else begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_got <= 1'b1;
            wr_addr <= awaddr;
         end
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_got <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp <= mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   logic [5:0] wr_word;
   logic [31:0] wr_ones;
   assign wr_word = wr_addr[7:2];
   assign wr_ones = wr_data & lane_mask(wr_strb);

   // ----------------------------------------------------------------
   // Interrupt flags
   // ----------------------------------------------------------------
   logic [N_IRQ-1:0] int_raw;
   logic [N_IRQ-1:0] int_ena;
   logic [N_IRQ-1:0] int_status;
   logic [N_IRQ-1:0] clear_mask;

   always_comb begin
      clear_mask = '0;
      if (wr_go && (wr_word == OFF_INT_CLR[7:2] ||
            wr_word == OFF_INT_RAW[7:2])) begin
         clear_mask = wr_ones[N_IRQ-1:0];
      end
   end

   // A new event in the clearing cycle keeps its flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_raw <= RST_INT;
      end else begin
         int_raw <= (int_raw & ~clear_mask) | ev_hit[N_IRQ-1:0];
      end
   end

   logic [31:0] next_ena;
   assign next_ena = merge(32'(int_ena), wr_data, wr_strb);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         int_ena <= RST_INT;
      end else if (wr_go && wr_word == OFF_INT_ENA[7:2]) begin
         int_ena <= next_ena[N_IRQ-1:0];
      end
   end

   assign int_status = int_raw & int_ena;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |int_status;
      end
   end

   // ----------------------------------------------------------------
   // Command slots
   // ----------------------------------------------------------------
   logic [31:0] slot [N_SLOT];
   logic [3:0] wr_slot;
   assign wr_slot = slot_of(wr_addr);

   // Done set by hardware wins over a software write in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < N_SLOT; i++) begin
            slot[i] <= RST_SLOT;
         end
      end else begin
         for (int i = 0; i < N_SLOT; i++) begin
            if (wr_go && wr_slot == 4'(i)) begin
               slot[i] <= merge(slot[i], wr_data, wr_strb) & CMD_MASK;
            end
            if (ev_hit[N_IRQ+i]) begin
               slot[i][CMD_DONE] <= 1'b1;
            end
         end
      end
   end

   // Fields go out flat; the engine samples them after the launch crosses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_words <= '0;
         slot_ops <= '0;
      end else begin
         for (int i = 0; i < N_SLOT; i++) begin
            slot_words[i*32 +: 32] <= slot[i];
            slot_ops[i*CMD_OP_W +: CMD_OP_W] <=
               op_decode(slot[i][CMD_OP_LSB +: CMD_OP_W]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Control, stall limits and version
   // ----------------------------------------------------------------
   logic launch_toggle;
   logic [31:0] version;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         launch_toggle <= 1'b0;
      end else if (wr_go && wr_word == OFF_CONTROL[7:2] &&
            wr_ones[CTL_LAUNCH]) begin
         launch_toggle <= ~launch_toggle;
      end
   end

   // Limits are stored as written; keeping them at 23 or less is up to
   // software, nothing here saturates them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clock_fsm_stall_limit <= RST_STALL;
         main_fsm_stall_limit <= RST_STALL;
      end else if (wr_go && wr_word == OFF_STALL[7:2]) begin
         if (wr_strb[0]) begin
            clock_fsm_stall_limit <= wr_data[STALL_CLK_LSB +: STALL_W];
         end
         if (wr_strb[1]) begin
            main_fsm_stall_limit <= wr_data[STALL_MAIN_LSB +: STALL_W];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         version <= VERSION;
      end else if (wr_go && wr_word == OFF_VERSION[7:2]) begin
         version <= merge(version, wr_data, wr_strb);
      end
   end

   // ----------------------------------------------------------------
   // Launch into the link domain
   // ----------------------------------------------------------------
   logic launch_sync1;
   logic launch_sync2;
   logic launch_seen;

   always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
         launch_sync1 <= 1'b0;
         launch_sync2 <= 1'b0;
         launch_seen <= 1'b0;
         link_launch <= 1'b0;
      end else begin
         launch_sync1 <= launch_toggle;
         launch_sync2 <= launch_sync1;
         launch_seen <= launch_sync2;
         link_launch <= launch_sync2 ^ launch_seen;
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a);
      logic [31:0] d;
      logic [3:0] s;
      d = '0;
      s = slot_of(a);
      if (s != 4'(N_SLOT)) begin
         d = slot[s[2:0]];
      end else begin
         unique case (a[7:2])
            OFF_INT_RAW[7:2]: d = 32'(int_raw);
            OFF_INT_ENA[7:2]: d = 32'(int_ena);
            OFF_INT_STATUS[7:2]: d = 32'(int_status);
            OFF_STALL[7:2]: begin
               d[STALL_CLK_LSB +: STALL_W] = clock_fsm_stall_limit;
               d[STALL_MAIN_LSB +: STALL_W] = main_fsm_stall_limit;
            end
            OFF_TX_BASE[7:2]: d = TX_BASE;
            OFF_RX_BASE[7:2]: d = RX_BASE;
            OFF_VERSION[7:2]: d = version;
            default: d = '0;
         endcase
      end
      return d;
   endfunction

   // Clear, control and unmapped words read as zero
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= read_word(araddr);
            rresp <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end
endmodule

// File: core/imc_pkg.sv
// Constants, field layouts and types for the I2C command/interrupt registers.
// Assumes a 32-bit AXI4-Lite register port with byte addresses of 8 bits.
package imc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int N_IRQ = 16;
   localparam int N_SLOT = 8;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_CONTROL = 8'h04;
   localparam logic [7:0] OFF_INT_RAW = 8'h20;
   localparam logic [7:0] OFF_INT_CLR = 8'h24;
   localparam logic [7:0] OFF_INT_ENA = 8'h28;
   localparam logic [7:0] OFF_INT_STATUS = 8'h2c;
   localparam logic [7:0] OFF_SLOT0 = 8'h58;
   localparam logic [7:0] OFF_STALL = 8'h78;
   localparam logic [7:0] OFF_TX_BASE = 8'h90;
   localparam logic [7:0] OFF_RX_BASE = 8'h94;
   localparam logic [7:0] OFF_VERSION = 8'hf8;

   // ----------------------------------------------------------------
   // Field layouts
   // ----------------------------------------------------------------
   localparam int CTL_LAUNCH = 0;
   localparam int STALL_W = 5;
   localparam int STALL_CLK_LSB = 0;
   localparam int STALL_MAIN_LSB = 8;
   localparam int CMD_COUNT_LSB = 0;
   localparam int CMD_COUNT_W = 8;
   localparam int CMD_ACK_CHECK = 8;
   localparam int CMD_ACK_EXP = 9;
   localparam int CMD_ACK_SEND = 10;
   localparam int CMD_OP_LSB = 11;
   localparam int CMD_OP_W = 3;
   localparam int CMD_DONE = 31;
   // Only these bits of a slot are stored; the rest read as zero
   localparam logic [31:0] CMD_MASK = 32'h8000_3fff;

   // Interrupt source bit positions
   localparam int IRQ_RX_WM = 0;
   localparam int IRQ_TX_WM = 1;
   localparam int IRQ_RX_OVF = 2;
   localparam int IRQ_END_DETECT = 3;
   localparam int IRQ_BYTE_DONE = 4;
   localparam int IRQ_ARB_LOST = 5;
   localparam int IRQ_TX_UDF = 6;
   localparam int IRQ_XFER_DONE = 7;
   localparam int IRQ_TIMEOUT = 8;
   localparam int IRQ_XFER_BEGUN = 9;
   localparam int IRQ_NACK = 10;
   localparam int IRQ_TX_OVF = 11;
   localparam int IRQ_RX_UDF = 12;
   localparam int IRQ_CLK_STALL = 13;
   localparam int IRQ_MAIN_STALL = 14;
   localparam int IRQ_START_SEEN = 15;

   // ----------------------------------------------------------------
   // Reset values and bus answers
   // ----------------------------------------------------------------
   localparam logic [N_IRQ-1:0] RST_INT = 16'h0000;
   localparam logic [31:0] RST_SLOT = 32'h0000_0000;
   localparam logic [STALL_W-1:0] RST_STALL = 5'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      OP_RESTART = 3'h0,
      OP_WRITE = 3'h1,
      OP_READ = 3'h2,
      OP_STOP = 3'h3,
      OP_END = 3'h4
   } imc_op_t;
endpackage

// File: tb/imc_regs_asserts.sv
// Checker for the register block: bus answers, slots, irq and launch.
// Bound to imc_regs; it sees only that module's ports.
module imc_regs_chk import imc_pkg::*; #(
   parameter logic [31:0] TX_BASE = 32'h0000_0000
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [DATA_W-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic irq,
   input wire logic link_clk,
   input wire logic link_resetn,
   input wire logic link_launch,
   input wire logic [N_SLOT*32-1:0] slot_words,
   input wire logic [N_SLOT*CMD_OP_W-1:0] slot_ops
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wr_go;
   logic rd_go;
   logic [31:0] wd_q;
   assign wr_go = awvalid && awready && wvalid && wready;
   assign rd_go = arvalid && arready;
   // Keeps the taken word so the slot check need not use a deep $past
   always_ff @(posedge aclk) begin
      if (wr_go) begin
         wd_q <= wdata;
      end
   end
   for (genvar i = 0; i < N_SLOT; i++) begin : g_op
      logic [2:0] op;
      assign op = slot_words[32*i+11 +: 3];
      a_op_decode: assert property (
         @(posedge aclk) disable iff (!aresetn)
         $stable(slot_words) |-> slot_ops[3*i +: 3] == (op > 3'h4 ? 3'h4 : op))
         else $error("slot opcode decode wrong");
   end
   // Slot word reaches the port two edges after the word is taken
   a_slot_store: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go && awaddr == OFF_SLOT0 && wstrb == 4'hf
      |-> ##3 slot_words[31:0] == (wd_q & CMD_MASK))
      else $error("slot word not stored");
   a_write_answer: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go |=> !awready && !wready ##1 bvalid)
      else $error("write answer late");
   a_b_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      bvalid && !bready |=> bvalid) else $error("write answer dropped");
   a_read_answer: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rd_go |=> rvalid && !arready) else $error("read answer late");
   a_r_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer changed");
   a_tx_base: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && araddr == OFF_TX_BASE |=> rdata == TX_BASE)
      else $error("transmit base wrong");
   a_clear_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      rd_go && araddr == OFF_INT_CLR |=> rdata == 32'h0)
      else $error("clear bits held a value");
   a_launch_zero: assert property (
      @(posedge aclk) disable iff (!aresetn)
      rd_go && araddr == OFF_CONTROL |=> !rdata[CTL_LAUNCH])
      else $error("launch bit reads set");
   // Enable lands one edge after the take, irq one edge after that
   a_irq_masked: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go && awaddr == OFF_INT_ENA && wstrb == 4'hf && wdata[15:0] == 16'h0
      |-> ##3 !irq [*3]) else $error("irq high with all masked");
   a_launch_pulse: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      link_launch |=> !link_launch) else $error("launch pulse too long");
endmodule
bind imc_regs imc_regs_chk #(.TX_BASE(TX_BASE)) u_chk (
   .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
   .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid),
   .rready(rready), .irq(irq), .link_clk(link_clk),
   .link_resetn(link_resetn), .link_launch(link_launch),
   .slot_words(slot_words), .slot_ops(slot_ops)
);

// File: tb/imc_link_model.sv
// Stand-in for the bus engine on the link clock: fires events, counts launches.
// Driven by testbench calls; one call at a time.
module imc_link_model import imc_pkg::*; (
   input wire logic link_clk,
   input wire logic link_launch,
   output logic [N_IRQ-1:0] event_pulse,
   output logic [N_SLOT-1:0] slot_done_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   int launches = 0;
   initial begin
      event_pulse = '0;
      slot_done_pulse = '0;
   end
   // One-cycle pulses; d link cycles of delay model a slow engine
   task automatic fire(input logic [15:0] ev, input logic [7:0] dn,
         input int d);
      repeat (d + 1) @(posedge link_clk);
      event_pulse <= ev;
      slot_done_pulse <= dn;
      @(posedge link_clk);
      event_pulse <= '0;
      slot_done_pulse <= '0;
   endtask
   always @(posedge link_clk) begin
      if (link_launch) begin
         launches <= launches + 1;
      end
   end
endmodule

// File: tb/testbench.sv
// Self-checking bench for imc_regs with an AXI4-Lite master.
// Assumes the link model and the bound checker are compiled alongside.
module testbench import imc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary base and revision values
   localparam logic [31:0] TXB = 32'h0000_0040;
   localparam logic [31:0] RXB = 32'h0000_00c0;
   localparam logic [31:0] VER = 32'h0002_0003;
   logic aclk = 0, aresetn = 0, link_clk = 0, link_resetn = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rv;
   logic [3:0] wstrb = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, link_launch;
   logic [1:0] bresp, rresp, rs;
   logic [N_IRQ-1:0] event_pulse;
   logic [N_SLOT-1:0] slot_done_pulse;
   logic [255:0] slot_words;
   logic [23:0] slot_ops;
   logic [4:0] clk_lim, main_lim;
   int fails = 0, total_checks = 0, lag = 0;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s;
      logic [31:0] e; logic [1:0] r;} imc_row_t;
   imc_row_t rows [12] = '{
      '{8'h58, 32'h8000_3fff, 4'hf, 32'h8000_3fff, RESP_OKAY},
      '{8'h74, 32'hffff_ffff, 4'hf, 32'h8000_3fff, RESP_OKAY},
      '{8'h64, 32'h0000_1a05, 4'hf, 32'h0000_1a05, RESP_OKAY},
      '{8'h5c, 32'hffff_ffff, 4'h1, 32'h0000_00ff, RESP_OKAY},
      '{8'h28, 32'h0000_a5a5, 4'hf, 32'h0000_a5a5, RESP_OKAY},
      '{8'h2c, 32'h0000_ffff, 4'hf, 32'h0000_0000, RESP_OKAY},
      '{8'h24, 32'h0000_ffff, 4'hf, 32'h0000_0000, RESP_OKAY},
      '{8'hf8, 32'h1234_5678, 4'hf, 32'h1234_5678, RESP_OKAY},
      '{8'h90, 32'hffff_ffff, 4'hf, TXB, RESP_OKAY},
      '{8'h94, 32'hffff_ffff, 4'hf, RXB, RESP_OKAY},
      '{8'h78, 32'h0000_1717, 4'hf, 32'h0000_1717, RESP_OKAY},
      '{8'h40, 32'hffff_ffff, 4'hf, 32'h0000_0000, RESP_SLVERR}
   };
   imc_regs #(.TX_BASE(TXB), .RX_BASE(RXB), .VERSION(VER)) dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .irq(irq), .link_clk(link_clk),
      .link_resetn(link_resetn), .event_pulse(event_pulse),
      .slot_done_pulse(slot_done_pulse), .link_launch(link_launch),
      .slot_words(slot_words), .slot_ops(slot_ops),
      .clock_fsm_stall_limit(clk_lim), .main_fsm_stall_limit(main_lim));
   imc_link_model u_link (.link_clk(link_clk), .link_launch(link_launch),
      .event_pulse(event_pulse), .slot_done_pulse(slot_done_pulse));
   initial begin
      forever #25 aclk = ~aclk;
   end
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end
   // ----------------------------------------------------------------
   // Bus tasks; lag holds the ready back to test slow masters
   // ----------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1;
      wvalid <= 1;
      bready <= (lag == 0);
      do begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (n >= lag) bready <= 1;
      end while (!(bvalid && bready));
      rs = bresp;
      bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1;
      rready <= (lag == 0);
      do begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 0;
         if (n >= lag) rready <= 1;
      end while (!(rvalid && rready));
      rv = rdata;
      rs = rresp;
      rready <= 0;
   endtask
   task automatic do_reset();
      @(posedge aclk);
      aresetn <= 0;
      link_resetn <= 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1;
      link_resetn <= 1;
   endtask
   task automatic give_verdict();
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #200us;
      fails++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      do_reset();
      foreach (rows[i]) begin
         lag = i % 3;
         wr(rows[i].a, rows[i].d, rows[i].s);
         cmp(rs, rows[i].r);
         rd(rows[i].a);
         cmp(rv, rows[i].e);
         cmp(rs, rows[i].r);
      end
      cmp({main_lim, clk_lim}, 10'h2f7);
      lag = 0;
      // Second reset in mid-run: version, slot 0, enables and clock limit must return
      do_reset();
      rd(OFF_VERSION);
      cmp(rv, VER);
      rd(OFF_SLOT0);
      cmp(rv, RST_SLOT);
      rd(OFF_INT_ENA);
      cmp(rv, 32'h0);
      cmp(clk_lim, RST_STALL);
      u_link.fire(16'hffff, 8'h00, 0);
      repeat (8) @(posedge aclk);
      rd(OFF_INT_RAW);
      cmp(rv, 32'h0000_ffff);
      cmp(irq, 1'b0);
      wr(OFF_INT_ENA, 32'h0000_a000, 4'hf);
      rd(OFF_INT_STATUS);
      cmp(rv, 32'h0000_a000);
      cmp(irq, 1'b1);
      wr(OFF_INT_CLR, 32'h0000_2000, 4'hf);
      rd(OFF_INT_RAW);
      cmp(rv, 32'h0000_dfff);
      cmp(irq, 1'b1);
      wr(OFF_INT_CLR, 32'h0000_8000, 4'h2);
      rd(OFF_INT_STATUS);
      cmp(rv, 32'h0);
      cmp(irq, 1'b0);
      wr(OFF_INT_CLR, 32'hffff_0000, 4'hf);
      rd(OFF_INT_RAW);
      cmp(rv, 32'h0000_5fff);
      wr(OFF_INT_ENA, 32'h0000_0fff, 4'hf);
      rd(OFF_INT_STATUS);
      cmp(rv, 32'h0000_0fff);
      cmp(irq, 1'b1);
      wr(OFF_INT_ENA, 32'h0, 4'hf);
      repeat (4) @(posedge aclk);
      cmp(irq, 1'b0);
      for (int op = 0; op < 8; op++) begin
         wr(8'h60, {18'h0, op[2:0], 11'h703}, 4'hf);
         @(posedge aclk);
         cmp(slot_ops[8:6], (op > 4) ? 3'h4 : op[2:0]);
         cmp(slot_words[95:64], {18'h0, op[2:0], 11'h703});
      end
      wr(OFF_SLOT0, 32'h0000_0801, 4'hf);
      u_link.fire(16'h0, 8'h01, 3);
      repeat (8) @(posedge aclk);
      rd(OFF_SLOT0);
      cmp(rv, 32'h8000_0801);
      wr(OFF_CONTROL, 32'h1, 4'hf);
      repeat (4) @(posedge aclk);
      cmp(u_link.launches, 1);
      rd(OFF_CONTROL);
      cmp(rv[0], 1'b0);
      give_verdict();
   end
endmodule
